/* File: src/pdnsc_pkg.sv */
// constants shared by the divider steering, stepping and spread control
//------------------------------------------------------------------------
//------------------------------------------------------------------------
package pdnsc_pkg;
    localparam int FB_W      = 42;
    localparam int FRAC_W    = 40;
    localparam int INC_W     = 24;
    localparam int INC_SHIFT = 7;
    localparam int STEP_W    = 32;
    localparam int CNT_W     = 16;
    localparam int NUM_GPIO  = 4;
    localparam int SRC_W     = 3;
    localparam int ADDR_W    = 8;

    // register byte offsets
    localparam logic [ADDR_W-1:0] OFS_CTRL   = 8'h00;
    localparam logic [ADDR_W-1:0] OFS_TRIG   = 8'h04;
    localparam logic [ADDR_W-1:0] OFS_STATUS = 8'h08;
    localparam logic [ADDR_W-1:0] OFS_STEP   = 8'h0c;
    localparam logic [ADDR_W-1:0] OFS_RAMP   = 8'h10;
    localparam logic [ADDR_W-1:0] OFS_FB_LO  = 8'h14;
    localparam logic [ADDR_W-1:0] OFS_FB_HI  = 8'h18;
    localparam logic [ADDR_W-1:0] OFS_FR_LO  = 8'h1c;
    localparam logic [ADDR_W-1:0] OFS_FR_HI  = 8'h20;

    // control register fields
    localparam int CTL_USE_FRAC  = 0;
    localparam int CTL_INCDEC_EN = 1;
    localparam int CTL_SPREAD_EN = 2;
    localparam int CTL_DOWN_SEL  = 3;
    localparam int CTL_RD_CUR    = 4;
    localparam int CTL_SPR_SRC   = 8;
    localparam int CTL_INC_SRC   = 12;
    localparam int CTL_DEC_SRC   = 16;

    // trigger and status fields
    localparam int TRG_INC     = 0;
    localparam int TRG_DEC     = 1;
    localparam int STS_LOCKED  = 0;
    localparam int STS_SPREAD  = 1;
    localparam int STS_RAMP_UP = 2;

    // reset values
    localparam logic [FB_W-1:0]   RST_NOM_FB   = 42'h000_0000_0000;
    localparam logic [FRAC_W-1:0] RST_NOM_FRAC = 40'h00_0000_0000;
    localparam logic [STEP_W-1:0] RST_STEP     = 32'h0000_0000;
    localparam logic [CNT_W-1:0]  RST_RAMP     = 16'h0000;
endpackage

/* File: src/pdnsc_sync_edge.sv */
// two-flop synchroniser with level output and either-edge toggle detect
`timescale 1ns/1ps
`default_nettype none
module pdnsc_sync_edge #(
    parameter int W = 1
) (
    // clock and reset
    input  wire logic         clk,
    input  wire logic         rst_n,
    // asynchronous inputs
    input  wire logic [W-1:0] din,
    // synchronised outputs
    output logic      [W-1:0] level,
    output logic      [W-1:0] toggle
);
    logic [W-1:0] meta;
    logic [W-1:0] prev;
    logic [W-1:0] next_toggle;

    // first stage feeds only the second stage
    always_comb begin
        next_toggle = level ^ prev;
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            meta   <= '0;
            level  <= '0;
            prev   <= '0;
            toggle <= '0;
        end else begin
            meta   <= din;
            level  <= meta;
            prev   <= level;
            toggle <= next_toggle;
        end
    end
endmodule
`default_nettype wire

/* File: src/pdnsc_top.sv */
// pll divider steering, trigger stepping and spread modulation with apb
//
// Local design decisions: the register addresses and the APB slave port.
`timescale 1ns/1ps
`default_nettype none
module pdnsc_top
    import pdnsc_pkg::*;
(
    // clock and reset
    input  wire logic              pclk,
    input  wire logic              presetn,
    // apb slave
    input  wire logic              psel,
    input  wire logic              penable,
    input  wire logic              pwrite,
    input  wire logic [ADDR_W-1:0] paddr,
    input  wire logic [31:0]       pwdata,
    output logic      [31:0]       prdata,
    output logic                   pready,
    output logic                   pslverr,
    // pll side
    input  wire logic              pll_locked_flag,
    input  wire logic              ref_tick,
    input  wire logic [NUM_GPIO-1:0] gpio,
    // divider outputs and spread status
    output logic      [FB_W-1:0]   fb_divider,
    output logic      [FRAC_W-1:0] frac_divider,
    output logic                   spread_active
);
    //--------------------------------------------------------------------
    // input synchronisers
    //--------------------------------------------------------------------
    logic [NUM_GPIO:0] sync_level;
    logic [NUM_GPIO:0] sync_tog;
    logic              locked;
    logic              lock_rise;

    pdnsc_sync_edge #(.W(NUM_GPIO + 1)) u_sync (
        .clk    (pclk),
        .rst_n  (presetn),
        .din    ({gpio, pll_locked_flag}),
        .level  (sync_level),
        .toggle (sync_tog)
    );

    assign locked    = sync_level[0];
    assign lock_rise = sync_level[0] & sync_tog[0];

    //--------------------------------------------------------------------
    // register state
    //--------------------------------------------------------------------
    logic              use_frac_divider_select;
    logic              inc_dec_enable;
    logic              spread_enable;
    logic              down_spread_select;
    logic              readback_current_select;
    logic [SRC_W-1:0]  spread_source_select;
    logic [SRC_W-1:0]  increment_source_select;
    logic [SRC_W-1:0]  decrement_source_select;
    logic [1:0]        sw_trig;
    logic [1:0]        sw_trig_prev;
    logic [STEP_W-1:0] step_size_value;
    logic [CNT_W-1:0]  ramp_cycle_count;
    logic [FB_W-1:0]   nominal_fb_divider;
    logic [FRAC_W-1:0] nominal_frac_out_divider;
    logic [31:0]       fb_lo_shadow;
    logic [31:0]       fr_lo_shadow;
    logic [FB_W:0]     spread_offset;
    logic [CNT_W:0]    phase_cnt;
    logic [1:0]        quarter;

    logic              next_use_frac, next_incdec, next_spr_en, next_down;
    logic              next_rd_cur;
    logic [SRC_W-1:0]  next_spr_src, next_inc_src, next_dec_src;
    logic [1:0]        next_sw_trig;
    logic [STEP_W-1:0] next_step;
    logic [CNT_W-1:0]  next_ramp;
    logic [FB_W-1:0]   next_nom_fb;
    logic [FRAC_W-1:0] next_nom_frac;
    logic [31:0]       next_fb_lo_shadow, next_fr_lo_shadow;
    logic [31:0]       next_prdata;
    logic              next_pready, next_pslverr;

    //--------------------------------------------------------------------
    // apb decode and register writes
    //--------------------------------------------------------------------
    logic        setup_phase;
    logic        access_wr;
    logic        addr_hit;
    logic        wr_fb_hi;
    logic        wr_fr_hi;
    logic [31:0] rd_value;
    logic [FB_W-1:0] fb_readback;

    assign setup_phase = psel & ~penable;
    assign access_wr   = psel & penable & pready & pwrite & ~pslverr;
    assign wr_fb_hi    = access_wr & (paddr == OFS_FB_HI);
    assign wr_fr_hi    = access_wr & (paddr == OFS_FR_HI);

    assign fb_readback = readback_current_select ? fb_divider
                                                 : nominal_fb_divider;

    always_comb begin
        addr_hit = 1'b1;
        rd_value = 32'h0000_0000;
        unique case (paddr)
            OFS_CTRL: begin
                rd_value[CTL_USE_FRAC]  = use_frac_divider_select;
                rd_value[CTL_INCDEC_EN] = inc_dec_enable;
                rd_value[CTL_SPREAD_EN] = spread_enable;
                rd_value[CTL_DOWN_SEL]  = down_spread_select;
                rd_value[CTL_RD_CUR]    = readback_current_select;
                rd_value[CTL_SPR_SRC +: SRC_W] = spread_source_select;
                rd_value[CTL_INC_SRC +: SRC_W] = increment_source_select;
                rd_value[CTL_DEC_SRC +: SRC_W] = decrement_source_select;
            end
            OFS_TRIG:   rd_value[1:0] = sw_trig;
            OFS_STATUS: begin
                rd_value[STS_LOCKED]  = locked;
                rd_value[STS_SPREAD]  = spread_active;
                rd_value[STS_RAMP_UP] = down_spread_select ? quarter[0]
                    : (quarter == 2'd0) | (quarter == 2'd3);
            end
            OFS_STEP:  rd_value = step_size_value;
            OFS_RAMP:  rd_value[CNT_W-1:0] = ramp_cycle_count;
            OFS_FB_LO: rd_value = fb_readback[31:0];
            OFS_FB_HI: rd_value[FB_W-33:0] = fb_readback[FB_W-1:32];
            OFS_FR_LO: rd_value = nominal_frac_out_divider[31:0];
            OFS_FR_HI: begin
                rd_value[FRAC_W-33:0] = nominal_frac_out_divider[FRAC_W-1:32];
            end
            default:   addr_hit = 1'b0;
        endcase
    end

    always_comb begin
        next_pready  = setup_phase;
        next_pslverr = setup_phase & ~addr_hit;
        next_prdata  = (setup_phase & ~pwrite) ? rd_value : 32'h0000_0000;
        next_use_frac     = use_frac_divider_select;
        next_incdec       = inc_dec_enable;
        next_spr_en       = spread_enable;
        next_down         = down_spread_select;
        next_rd_cur       = readback_current_select;
        next_spr_src      = spread_source_select;
        next_inc_src      = increment_source_select;
        next_dec_src      = decrement_source_select;
        next_sw_trig      = sw_trig;
        next_step         = step_size_value;
        next_ramp         = ramp_cycle_count;
        next_nom_fb       = nominal_fb_divider;
        next_nom_frac     = nominal_frac_out_divider;
        next_fb_lo_shadow = fb_lo_shadow;
        next_fr_lo_shadow = fr_lo_shadow;
        if (access_wr) begin
            unique case (paddr)
                OFS_CTRL: begin
                    next_use_frac = pwdata[CTL_USE_FRAC];
                    next_incdec   = pwdata[CTL_INCDEC_EN];
                    next_spr_en   = pwdata[CTL_SPREAD_EN];
                    next_down     = pwdata[CTL_DOWN_SEL];
                    next_rd_cur   = pwdata[CTL_RD_CUR];
                    next_spr_src  = pwdata[CTL_SPR_SRC +: SRC_W];
                    next_inc_src  = pwdata[CTL_INC_SRC +: SRC_W];
                    next_dec_src  = pwdata[CTL_DEC_SRC +: SRC_W];
                end
                OFS_TRIG:  next_sw_trig = pwdata[1:0];
                OFS_STEP:  next_step    = pwdata;
                OFS_RAMP:  next_ramp    = pwdata[CNT_W-1:0];
                // low word is staged so the divider changes in one step
                OFS_FB_LO: next_fb_lo_shadow = pwdata;
                OFS_FB_HI: next_nom_fb = {pwdata[FB_W-33:0], fb_lo_shadow};
                OFS_FR_LO: next_fr_lo_shadow = pwdata;
                OFS_FR_HI: begin
                    next_nom_frac = {pwdata[FRAC_W-33:0], fr_lo_shadow};
                end
                default: ;
            endcase
        end
    end

    //--------------------------------------------------------------------
    // trigger selection
    //--------------------------------------------------------------------
    // source 0 is the software trigger bit, 1..4 pick a gpio
    logic [NUM_GPIO:0] inc_edges, dec_edges;
    logic              inc_edge, dec_edge;
    logic              spread_req;

    assign inc_edges = {sync_tog[NUM_GPIO:1], sw_trig[TRG_INC]
                        ^ sw_trig_prev[TRG_INC]};
    assign dec_edges = {sync_tog[NUM_GPIO:1], sw_trig[TRG_DEC]
                        ^ sw_trig_prev[TRG_DEC]};
    assign inc_edge  = (increment_source_select <= SRC_W'(NUM_GPIO))
                     & inc_edges[increment_source_select];
    assign dec_edge  = (decrement_source_select <= SRC_W'(NUM_GPIO))
                     & dec_edges[decrement_source_select];

    assign spread_req = (spread_source_select == '0) ? spread_enable
        : (spread_source_select <= SRC_W'(NUM_GPIO))
          & sync_level[spread_source_select];

    //--------------------------------------------------------------------
    // divider steering, stepping and spread
    //--------------------------------------------------------------------
    logic            step_mode;
    logic            spread_on;
    logic            ramp_up;
    logic            quarter_end;
    logic [FB_W-1:0] step_amt;
    logic [FB_W:0]   spread_step;
    logic [FB_W-1:0] next_fb;
    logic [FRAC_W-1:0] next_frac;
    logic [FB_W:0]   next_offset;
    logic [CNT_W:0]  next_phase;
    logic [1:0]      next_quarter;

    // stepping wins if software enables both modes
    assign step_mode = ~use_frac_divider_select & inc_dec_enable;
    assign spread_on = spread_req & ~use_frac_divider_select
                     & ~inc_dec_enable & locked;
    assign step_amt  = {{(FB_W-INC_W-INC_SHIFT){1'b0}},
                        step_size_value[INC_W-1:0], {INC_SHIFT{1'b0}}};
    assign spread_step = {{(FB_W+1-STEP_W){1'b0}}, step_size_value};
    // center: up, down, down, up; down spread: down, up
    assign ramp_up   = down_spread_select ? quarter[0]
                     : (quarter == 2'd0) | (quarter == 2'd3);
    assign quarter_end = phase_cnt == ({1'b0, ramp_cycle_count}
                                       + (CNT_W+1)'(1));

    always_comb begin
        next_offset  = spread_offset;
        next_phase   = phase_cnt;
        next_quarter = quarter;
        if (!spread_on) begin
            next_offset  = '0;
            next_phase   = '0;
            next_quarter = 2'd0;
        end else if (ref_tick) begin
            next_offset = ramp_up ? spread_offset + spread_step
                                  : spread_offset - spread_step;
            if (quarter_end) begin
                next_phase   = '0;
                next_quarter = down_spread_select ? {1'b0, ~quarter[0]}
                                                  : quarter + 2'd1;
            end else begin
                next_phase = phase_cnt + (CNT_W+1)'(1);
            end
        end
    end

    always_comb begin
        next_frac = next_nom_frac;
        next_fb   = fb_divider;
        if (lock_rise) begin
            next_fb = next_nom_fb;
        end else if (spread_on) begin
            next_fb = next_nom_fb + next_offset[FB_W-1:0];
        end else if (step_mode) begin
            // a divider left mid-ramp by spread must not seed the steps
            if (wr_fb_hi || spread_active) begin
                next_fb = next_nom_fb;
            end else if (locked) begin
                next_fb = fb_divider + (inc_edge ? step_amt : '0)
                                     - (dec_edge ? step_amt : '0);
            end
        end else begin
            next_fb = next_nom_fb;
        end
    end

    //--------------------------------------------------------------------
    // registers
    //--------------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata                   <= 32'h0000_0000;
            pready                   <= 1'b0;
            pslverr                  <= 1'b0;
            use_frac_divider_select  <= 1'b0;
            inc_dec_enable           <= 1'b0;
            spread_enable            <= 1'b0;
            down_spread_select       <= 1'b0;
            readback_current_select  <= 1'b0;
            spread_source_select     <= '0;
            increment_source_select  <= '0;
            decrement_source_select  <= '0;
            sw_trig                  <= 2'h0;
            sw_trig_prev             <= 2'h0;
            step_size_value          <= RST_STEP;
            ramp_cycle_count         <= RST_RAMP;
            nominal_fb_divider       <= RST_NOM_FB;
            nominal_frac_out_divider <= RST_NOM_FRAC;
            fb_lo_shadow             <= 32'h0000_0000;
            fr_lo_shadow             <= 32'h0000_0000;
            spread_offset            <= '0;
            phase_cnt                <= '0;
            quarter                  <= 2'd0;
            fb_divider               <= RST_NOM_FB;
            frac_divider             <= RST_NOM_FRAC;
            spread_active            <= 1'b0;
        end else begin
            prdata                   <= next_prdata;
            pready                   <= next_pready;
            pslverr                  <= next_pslverr;
            use_frac_divider_select  <= next_use_frac;
            inc_dec_enable           <= next_incdec;
            spread_enable            <= next_spr_en;
            down_spread_select       <= next_down;
            readback_current_select  <= next_rd_cur;
            spread_source_select     <= next_spr_src;
            increment_source_select  <= next_inc_src;
            decrement_source_select  <= next_dec_src;
            sw_trig                  <= next_sw_trig;
            sw_trig_prev             <= sw_trig;
            step_size_value          <= next_step;
            ramp_cycle_count         <= next_ramp;
            nominal_fb_divider       <= next_nom_fb;
            nominal_frac_out_divider <= next_nom_frac;
            fb_lo_shadow             <= next_fb_lo_shadow;
            fr_lo_shadow             <= next_fr_lo_shadow;
            spread_offset            <= next_offset;
            phase_cnt                <= next_phase;
            quarter                  <= next_quarter;
            fb_divider               <= next_fb;
            frac_divider             <= next_frac;
            spread_active            <= spread_on;
        end
    end
endmodule
`default_nettype wire

/* File: test/pdnsc_pll_model.sv */
// behavioural pll: lock flag and one tick per pll input clock cycle
`timescale 1ns/1ps
`default_nettype none
module pdnsc_pll_model #(
    parameter int TICK_DIV = 4
) (
    // clock and reset
    input  wire logic pclk,
    input  wire logic presetn,
    // lock request from the bench
    input  wire logic lock_req,
    // pll status
    output logic      pll_locked_flag,
    output logic      ref_tick
);
    int div_cnt;
    // the input clock keeps running while unlocked; only the flag drops
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            div_cnt <= 0;
            ref_tick <= 1'b0;
            pll_locked_flag <= 1'b0;
        end else begin
            div_cnt <= (div_cnt == TICK_DIV - 1) ? 0 : div_cnt + 1;
            ref_tick <= (div_cnt == TICK_DIV - 1);
            pll_locked_flag <= lock_req;
        end
    end
endmodule
`default_nettype wire

/* File: test/pdnsc_props.sv */
// concurrent checks on the pll divider control block ports
`timescale 1ns/1ps
`default_nettype none
module pdnsc_props
    import pdnsc_pkg::*;
(
    // clock and reset
    input wire logic                pclk,
    input wire logic                presetn,
    // apb
    input wire logic                psel,
    input wire logic                penable,
    input wire logic                pwrite,
    input wire logic [ADDR_W-1:0]   paddr,
    input wire logic [31:0]         pwdata,
    input wire logic [31:0]         prdata,
    input wire logic                pready,
    input wire logic                pslverr,
    // pll side and outputs
    input wire logic                pll_locked_flag,
    input wire logic                ref_tick,
    input wire logic [NUM_GPIO-1:0] gpio,
    input wire logic [FB_W-1:0]     fb_divider,
    input wire logic [FRAC_W-1:0]   frac_divider,
    input wire logic                spread_active
);
    logic       wr_done;
    logic       wr_frac;
    logic [2:0] unl_cnt;
    logic [2:0] next_unl_cnt;
    logic [2:0] wr_age;
    logic [2:0] next_wr_age;
    assign wr_done = psel && penable && pready && pwrite;
    assign wr_frac = wr_done && (paddr == OFS_FR_HI);
    // both ages saturate, so a long idle spell never wraps to look fresh
    always_comb begin
        next_unl_cnt = pll_locked_flag ? 3'h0
                                       : unl_cnt + {2'h0, unl_cnt != 3'h7};
        next_wr_age = wr_done ? 3'h0 : wr_age + {2'h0, wr_age != 3'h7};
    end
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            unl_cnt <= 3'h0;
            wr_age <= 3'h7;
        end else begin
            unl_cnt <= next_unl_cnt;
            wr_age <= next_wr_age;
        end
    end
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    a_ready_setup: assert property (psel && !penable |=> pready)
        else $error("ready missing after setup");
    a_ready_single: assert property (pready |=> !pready)
        else $error("ready held two cycles");
    a_ready_idle: assert property (!psel |=> !pready)
        else $error("ready without request");
    a_err_unmapped: assert property (
        pready && paddr > OFS_FR_HI |-> pslverr)
        else $error("unmapped access not refused");
    a_err_mapped: assert property (
        pready && paddr <= OFS_FR_HI && paddr[1:0] == 2'h0 |-> !pslverr)
        else $error("mapped access refused");
    a_rdata_idle: assert property (!pready |-> prdata == 32'h0)
        else $error("read data outside access");
    a_frac_write: assert property (
        $changed(frac_divider) |-> $past(wr_frac) || $past(wr_frac, 2))
        else $error("fractional divider moved without write");
    a_spread_unlocked: assert property (
        !pll_locked_flag [*5] |-> !spread_active)
        else $error("spread running while unlocked");
    a_fb_frozen: assert property (
        $changed(fb_divider) |-> unl_cnt < 3'h6 || wr_age < 3'h4)
        else $error("divider moved while unlocked");
    c_frac_wr: cover property (wr_frac);
    c_spread_on: cover property ($rose(spread_active));
    c_refused: cover property (pready && pslverr);
endmodule
bind pdnsc_top pdnsc_props chk_u (.pclk, .presetn, .psel, .penable, .pwrite,
    .paddr, .pwdata, .prdata, .pready, .pslverr, .pll_locked_flag, .ref_tick,
    .gpio, .fb_divider, .frac_divider, .spread_active);
`default_nettype wire

/* File: test/tb.sv */
// self-checking bench for the pll divider control block
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin cmp_count++; if ((g) !== (e)) begin fails++; \
    $display("ERROR %0t: got %h expected %h", $time, (g), (e)); end end
module tb
    import pdnsc_pkg::*;
;
    typedef struct packed {
        logic wr; logic [7:0] a; logic [31:0] d; logic [31:0] e; logic er;
    } pdnsc_row_t;
    localparam logic [FB_W-1:0] NOM = 42'h001_8000_0000;
    localparam logic [FB_W-1:0] DLT = 42'h000_0000_8000;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, lock_req;
    logic pll_locked_flag, ref_tick, spread_active, er;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [NUM_GPIO-1:0] gpio;
    logic [FB_W-1:0] fb_divider, mx, mn;
    logic [FRAC_W-1:0] frac_divider;
    int fails, cmp_count;
    pdnsc_row_t rows [20];
    pdnsc_top dut_u (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
        .pwdata, .prdata, .pready, .pslverr, .pll_locked_flag, .ref_tick,
        .gpio, .fb_divider, .frac_divider, .spread_active);
    pdnsc_pll_model pll_u (.pclk, .presetn, .lock_req, .pll_locked_flag,
        .ref_tick);
    initial begin
        pclk = 1'b0;
        forever #20 pclk = ~pclk;
    end
    task automatic print_verdict;
        $display("comparisons %0d mismatches %0d", cmp_count, fails);
        if (fails == 0 && cmp_count > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge pclk);
    endtask
    // one apb transfer; pready, read data and error are taken at one edge
    task automatic apb(input logic w, input logic [7:0] a,
                       input logic [31:0] d);
        int n;
        n = 0;
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1 && n < 16) begin
            @(posedge pclk);
            n++;
        end
        if (n == 16) fails++;
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic track(input int n);
        mx = fb_divider;
        mn = fb_divider;
        repeat (n) begin
            @(negedge pclk);
            if (fb_divider > mx) mx = fb_divider;
            if (fb_divider < mn) mn = fb_divider;
        end
    endtask
    initial begin
        repeat (20000) @(posedge pclk);
        fails++;
        print_verdict();
    end
    initial begin
        {presetn, psel, penable, pwrite, paddr, pwdata} = '0;
        gpio = '0;
        lock_req = 1'b1;
        rows = '{'{0, OFS_CTRL, 0, 0, 0}, '{0, OFS_STEP, 0, 0, 0},
            '{0, OFS_RAMP, 0, 0, 0}, '{0, OFS_FB_LO, 0, 0, 0},
            '{0, OFS_FB_HI, 0, 0, 0}, '{0, OFS_FR_HI, 0, 0, 0},
            '{1, OFS_STEP, 32'hff00_0100, 0, 0},
            '{0, OFS_STEP, 0, 32'hff00_0100, 0},
            '{1, OFS_RAMP, 32'h0001_0000, 0, 0}, '{0, OFS_RAMP, 0, 0, 0},
            '{1, OFS_FB_LO, 32'h8000_0000, 0, 0},
            '{1, OFS_FB_HI, 32'hffff_fc01, 0, 0},
            '{0, OFS_FB_HI, 0, 32'h0000_0001, 0},
            '{0, OFS_FB_LO, 0, 32'h8000_0000, 0},
            '{1, OFS_FR_LO, 32'h0000_1000, 0, 0},
            '{1, OFS_FR_HI, 32'hffff_ff05, 0, 0},
            '{0, OFS_FR_HI, 0, 32'h0000_0005, 0},
            '{0, OFS_STATUS, 0, 32'h0000_0005, 0},
            '{0, 8'h40, 0, 0, 1}, '{1, 8'h44, 32'hffff_ffff, 0, 1}};
        repeat (5) @(posedge pclk);
        presetn <= 1'b1;
        foreach (rows[i]) begin
            apb(rows[i].wr, rows[i].a, rows[i].d);
            if (!rows[i].wr) `CHK(rd, rows[i].e)
            `CHK(er, rows[i].er)
        end
        cyc(2);
        `CHK(fb_divider, NOM)
        `CHK(frac_divider, 40'h05_0000_1000)
        // steps of a few ppm stay inside drift limits
        // no remainder or denominator here
        apb(1, OFS_CTRL, 32'h0000_0012);
        apb(1, OFS_TRIG, 32'h1);
        apb(1, OFS_TRIG, 32'h0);
        cyc(3);
        `CHK(fb_divider, NOM + 2 * DLT)
        apb(0, OFS_FB_LO, 0);
        `CHK(rd, 32'h8001_0000)
        apb(1, OFS_CTRL, 32'h0000_1002);
        apb(0, OFS_FB_LO, 0);
        `CHK(rd, 32'h8000_0000)
        apb(1, OFS_TRIG, 32'h2);
        cyc(3);
        `CHK(fb_divider, NOM + DLT)
        gpio[0] <= 1'b1;
        cyc(6);
        gpio[0] <= 1'b0;
        cyc(6);
        `CHK(fb_divider, NOM + 3 * DLT)
        lock_req <= 1'b0;
        cyc(6);
        gpio[0] <= 1'b1;
        cyc(6);
        `CHK(fb_divider, NOM + 3 * DLT)
        lock_req <= 1'b1;
        cyc(6);
        `CHK(fb_divider, NOM)
        gpio[0] <= 1'b0;
        cyc(6);
        `CHK(fb_divider, NOM + DLT)
        // jumps on purpose; software would first step back
        apb(1, OFS_CTRL, 32'h0);
        cyc(2);
        `CHK(fb_divider, NOM)
        // small count and step stand in for derived values
        apb(1, OFS_STEP, 32'h0000_0400);
        apb(1, OFS_CTRL, 32'h0000_0004);
        track(80);
        `CHK(spread_active, 1'b1)
        `CHK(mx, NOM + 42'h800)
        `CHK(mn, NOM - 42'h800)
        apb(1, OFS_CTRL, 32'h0);
        apb(1, OFS_CTRL, 32'h0000_000c);
        track(80);
        `CHK(mx, NOM)
        `CHK(mn, NOM - 42'h800)
        lock_req <= 1'b0;
        cyc(8);
        `CHK(spread_active, 1'b0)
        `CHK(fb_divider, NOM)
        lock_req <= 1'b1;
        apb(1, OFS_CTRL, 32'h0000_0200);
        gpio[1] <= 1'b1;
        cyc(8);
        `CHK(spread_active, 1'b1)
        apb(1, OFS_CTRL, 32'h0000_0206);
        cyc(4);
        `CHK(spread_active, 1'b0)
        `CHK(fb_divider, NOM)
        apb(1, OFS_CTRL, 32'h0000_0005);
        cyc(4);
        `CHK(spread_active, 1'b0)
        `CHK(fb_divider, NOM)
        print_verdict();
    end
endmodule
`default_nettype wire
